/* File: rtl/nrtfc_pkg.sv */
`default_nettype none
// =====================================================================
// Shared constants for rate and Type A framing configuration
// =====================================================================
package nrtfc_pkg;
   // Register port widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;

   // Register offsets
   localparam logic [7:0] ADDR_LINK_SPEED = 8'h04; // Transmit and receive rate
   localparam logic [7:0] ADDR_FRAME_SET = 8'h05;  // Type A framing settings
   localparam logic [7:0] ADDR_STATUS = 8'h10;     // Derived state, read only

   // Reset values
   localparam logic [7:0] LINK_SPEED_RST = 8'h00;
   localparam logic [7:0] FRAME_SET_RST = 8'h00;

   // Speed register field positions
   localparam int TX_RATE_LSB = 4;
   localparam int RX_RATE_LSB = 0;
   localparam int RATE_W = 2;

   // Framing register field positions
   localparam int BIT_NO_TX_PARITY = 7;
   localparam int BIT_RAW_RX = 6;
   localparam int BIT_HEADER = 5;
   localparam int PULSE_LSB = 1;
   localparam int PULSE_FIELD_W = 4;
   localparam int BIT_ANTICOLL = 0;

   // Status register bit positions
   localparam int ST_LINK_EN = 0;
   localparam int ST_PULSE_OK = 1;
   localparam int ST_RAW_RX = 2;
   localparam int ST_HEADER = 3;

   // Rate codes
   localparam logic [1:0] RATE_DIV128 = 2'h0; // About 106 kbit/s
   localparam logic [1:0] RATE_DIV64 = 2'h1;
   localparam logic [1:0] RATE_DIV32 = 2'h2;
   localparam logic [1:0] RATE_DIV16 = 2'h3;  // About 848 kbit/s

   // Carrier divisors per rate
   localparam logic [7:0] DIV_128 = 8'h80;
   localparam logic [7:0] DIV_64 = 8'h40;
   localparam logic [7:0] DIV_32 = 8'h20;
   localparam logic [7:0] DIV_16 = 8'h10;
   localparam logic [7:0] DIV_NONE = 8'h00;

   // Pulse width in carrier periods: base and legal span per rate
   localparam int PW_W = 6;
   localparam logic [5:0] PW_BASE_128 = 6'h23; // 35
   localparam logic [5:0] PW_MIN_128 = 6'h1B;  // 27
   localparam logic [5:0] PW_MAX_128 = 6'h2A;  // 42
   localparam logic [5:0] PW_BASE_64 = 6'h12;  // 18
   localparam logic [5:0] PW_MIN_64 = 6'h0C;   // 12
   localparam logic [5:0] PW_MAX_64 = 6'h18;   // 24
   localparam logic [5:0] PW_BASE_32 = 6'h09;  // 9
   localparam logic [5:0] PW_MIN_32 = 6'h05;   // 5
   localparam logic [5:0] PW_MAX_32 = 6'h0D;   // 13
   localparam logic [5:0] PW_BASE_16 = 6'h05;  // 5
   localparam logic [5:0] PW_MIN_16 = 6'h02;   // 2
   localparam logic [5:0] PW_MAX_16 = 6'h08;   // 8

   // Transport frame start byte
   localparam logic [7:0] START_BYTE = 8'hF0;
endpackage
`default_nettype wire

/* File: rtl/nrtfc_pulse_calc.sv */
`default_nettype none
// =====================================================================
// Modulation pause width from rate and signed trim field
// =====================================================================
module nrtfc_pulse_calc
(
   input wire logic [1:0] rate_i,
   input wire logic [3:0] field_i,
   output logic [5:0] width_o,
   output logic valid_o
);
   // Trim field as signed, widened to the width result
   logic [5:0] trim;
   // Selected base and span
   logic [5:0] base;
   logic [5:0] lo;
   logic [5:0] hi;

   assign trim = {{2{field_i[3]}}, field_i};

   // Base and span per rate
   always_comb
   begin
      unique case (rate_i)
         nrtfc_pkg::RATE_DIV128:
         begin
            base = nrtfc_pkg::PW_BASE_128;
            lo = nrtfc_pkg::PW_MIN_128;
            hi = nrtfc_pkg::PW_MAX_128;
         end
         nrtfc_pkg::RATE_DIV64:
         begin
            base = nrtfc_pkg::PW_BASE_64;
            lo = nrtfc_pkg::PW_MIN_64;
            hi = nrtfc_pkg::PW_MAX_64;
         end
         nrtfc_pkg::RATE_DIV32:
         begin
            base = nrtfc_pkg::PW_BASE_32;
            lo = nrtfc_pkg::PW_MIN_32;
            hi = nrtfc_pkg::PW_MAX_32;
         end
         nrtfc_pkg::RATE_DIV16:
         begin
            base = nrtfc_pkg::PW_BASE_16;
            lo = nrtfc_pkg::PW_MIN_16;
            hi = nrtfc_pkg::PW_MAX_16;
         end
      endcase
   end

   // Wrap is harmless: every legal result stays positive
   always_comb
   begin
      width_o = 6'(base + trim);
      valid_o = (width_o >= lo) && (width_o <= hi);
   end
endmodule
`default_nettype wire

/* File: rtl/nrtfc_cfg.sv */
// Operation
// - Bits 5:4 select transmit rate
// - Bits 1:0 select receive rate
// - Codes map to carrier divided by 128..16
// - Unsupported rate disables transmit and receive
// - Bit 7 sends data without parity
// - Bit 6 stores raw bits, only 106k
// - Raw parity options honoured in reader only
// - Bit 5 adds header, drops received F0, except in rate detection
// - Bits 4:1 trim pause width in carriers
// - Slowest rate width is 35 plus trim
// - Faster rates use bases 18, 9, 5
// - Bit 0 selects anticollision receive framing
`default_nettype none
module nrtfc_cfg
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic reader_mode_i,
   input wire logic rate_detect_i,
   output logic [1:0] tx_rate_o,
   output logic [1:0] rx_rate_o,
   output logic [7:0] tx_divider_o,
   output logic [7:0] rx_divider_o,
   output logic tx_enable_o,
   output logic rx_enable_o,
   output logic tx_no_parity_o,
   output logic rx_raw_parity_o,
   output logic tx_header_o,
   output logic rx_skip_start_o,
   output logic [7:0] start_byte_o,
   output logic [5:0] pulse_width_o,
   output logic pulse_valid_o,
   output logic anticoll_o
);
   // =====================================================================
   // Helper functions
   // =====================================================================

   // Rate code to carrier divisor, zero when unsupported
   function automatic logic [7:0] rate_divider(input logic [1:0] code);
      logic [7:0] div;
      div = nrtfc_pkg::DIV_NONE;
      unique case (code)
         nrtfc_pkg::RATE_DIV128: div = nrtfc_pkg::DIV_128;
         nrtfc_pkg::RATE_DIV64: div = nrtfc_pkg::DIV_64;
         nrtfc_pkg::RATE_DIV32: div = nrtfc_pkg::DIV_32;
         nrtfc_pkg::RATE_DIV16: div = nrtfc_pkg::DIV_16;
      endcase
      return div;
   endfunction

   // Supported when a divisor exists; kept general for wider codes
   function automatic logic rate_supported(input logic [1:0] code);
      return rate_divider(code) != nrtfc_pkg::DIV_NONE;
   endfunction

   // =====================================================================
   // Register state
   // =====================================================================
   logic [1:0] tx_rate_reg; // Stored transmit rate code
   logic [1:0] rx_rate_reg; // Stored receive rate code
   logic [7:0] frame_reg;   // Framing settings, all eight bits used
   logic wr_speed;          // Write hits speed register
   logic wr_frame;          // Write hits framing register

   // Derived values ahead of the output flops
   logic link_en_next;
   logic no_par_next;
   logic raw_rx_next;
   logic header_next;
   logic [5:0] pw_calc;
   logic pw_ok_calc;
   logic [7:0] status_next;

   assign wr_speed = wr_i && (addr_i == nrtfc_pkg::ADDR_LINK_SPEED);
   assign wr_frame = wr_i && (addr_i == nrtfc_pkg::ADDR_FRAME_SET);

   // Speed register: only the two rate fields have storage
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         tx_rate_reg <= nrtfc_pkg::LINK_SPEED_RST[nrtfc_pkg::TX_RATE_LSB +: nrtfc_pkg::RATE_W];
         rx_rate_reg <= nrtfc_pkg::LINK_SPEED_RST[nrtfc_pkg::RX_RATE_LSB +: nrtfc_pkg::RATE_W];
      end
      else if (wr_speed)
      begin
         // Reserved bits dropped here so they can steer nothing
         tx_rate_reg <= wdata_i[nrtfc_pkg::TX_RATE_LSB +: nrtfc_pkg::RATE_W];
         rx_rate_reg <= wdata_i[nrtfc_pkg::RX_RATE_LSB +: nrtfc_pkg::RATE_W];
      end
   end

   // Framing register
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         frame_reg <= nrtfc_pkg::FRAME_SET_RST;
      end
      else if (wr_frame)
      begin
         frame_reg <= wdata_i;
      end
   end

   // =====================================================================
   // Pulse width arithmetic
   // =====================================================================
   nrtfc_pulse_calc u_pulse
   (
      .rate_i(tx_rate_reg),
      .field_i(frame_reg[nrtfc_pkg::PULSE_LSB +: nrtfc_pkg::PULSE_FIELD_W]),
      .width_o(pw_calc),
      .valid_o(pw_ok_calc)
   );

   // =====================================================================
   // Decode of control bits
   // =====================================================================

   // Both directions stop if either rate is unusable, so a
   // half-configured link never talks at an odd speed
   always_comb
   begin
      link_en_next = rate_supported(tx_rate_reg) && rate_supported(rx_rate_reg);
      // Raw parity modes ignored outside reader operation
      no_par_next = frame_reg[nrtfc_pkg::BIT_NO_TX_PARITY] && reader_mode_i;
      raw_rx_next = frame_reg[nrtfc_pkg::BIT_RAW_RX] && reader_mode_i
                    && (rx_rate_reg == nrtfc_pkg::RATE_DIV128);
      // Gated in rate detection as a guard against a software slip
      header_next = frame_reg[nrtfc_pkg::BIT_HEADER] && !rate_detect_i;
   end

   // Status word: the block's decoded state
   always_comb
   begin
      status_next = 8'h00;
      status_next[nrtfc_pkg::ST_LINK_EN] = tx_enable_o;
      status_next[nrtfc_pkg::ST_PULSE_OK] = pulse_valid_o;
      status_next[nrtfc_pkg::ST_RAW_RX] = rx_raw_parity_o;
      status_next[nrtfc_pkg::ST_HEADER] = tx_header_o;
   end

   // =====================================================================
   // Output flops toward encoder and decoder
   // =====================================================================

   // Rate outputs
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         tx_rate_o <= nrtfc_pkg::RATE_DIV128;
         rx_rate_o <= nrtfc_pkg::RATE_DIV128;
         tx_divider_o <= nrtfc_pkg::DIV_NONE;
         rx_divider_o <= nrtfc_pkg::DIV_NONE;
         tx_enable_o <= 1'b0;
         rx_enable_o <= 1'b0;
      end
      else
      begin
         tx_rate_o <= tx_rate_reg;
         rx_rate_o <= rx_rate_reg;
         tx_divider_o <= rate_divider(tx_rate_reg);
         rx_divider_o <= rate_divider(rx_rate_reg);
         tx_enable_o <= link_en_next;
         rx_enable_o <= link_en_next;
      end
   end

   // Framing outputs
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         tx_no_parity_o <= 1'b0;
         rx_raw_parity_o <= 1'b0;
         tx_header_o <= 1'b0;
         rx_skip_start_o <= 1'b0;
         anticoll_o <= 1'b0;
         start_byte_o <= 8'h00;
      end
      else
      begin
         tx_no_parity_o <= no_par_next;
         rx_raw_parity_o <= raw_rx_next;
         tx_header_o <= header_next;
         rx_skip_start_o <= header_next;
         anticoll_o <= frame_reg[nrtfc_pkg::BIT_ANTICOLL];
         start_byte_o <= nrtfc_pkg::START_BYTE;
      end
   end

   // Pulse width output; zero width flags an undefined setting too
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pulse_width_o <= 6'h00;
         pulse_valid_o <= 1'b0;
      end
      else
      begin
         pulse_width_o <= pw_ok_calc ? pw_calc : 6'h00;
         pulse_valid_o <= pw_ok_calc;
      end
   end

   // =====================================================================
   // Read port
   // =====================================================================

   // Data one cycle after the strobe; unmapped offsets read zero
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rdata_o <= 8'h00;
      end
      else if (rd_i)
      begin
         unique case (addr_i)
            nrtfc_pkg::ADDR_LINK_SPEED:
            begin
               // Reserved bits 7:6 and 3:2 read zero
               rdata_o <= {2'h0, tx_rate_reg, 2'h0, rx_rate_reg};
            end
            nrtfc_pkg::ADDR_FRAME_SET: rdata_o <= frame_reg;
            nrtfc_pkg::ADDR_STATUS: rdata_o <= status_next;
            default: rdata_o <= 8'h00;
         endcase
      end
      else
      begin
         rdata_o <= 8'h00;
      end
   end

   // =====================================================================
   // Assertions
   // =====================================================================

   // Write to speed register, then two cycles of settling
   sequence s_speed_write;
      wr_i && (addr_i == nrtfc_pkg::ADDR_LINK_SPEED);
   endsequence

   sequence s_frame_write;
      wr_i && (addr_i == nrtfc_pkg::ADDR_FRAME_SET);
   endsequence

   property p_tx_rate;
      @(posedge mclk_i) disable iff (!rst_n_i)
      s_speed_write ##1 !(wr_i && (addr_i == nrtfc_pkg::ADDR_LINK_SPEED))
      |=> tx_rate_o == $past(wdata_i[5:4], 2);
   endproperty
   a_tx_rate: assert property (p_tx_rate) else $error("transmit rate not taken from bits 5:4");

   property p_rx_rate;
      @(posedge mclk_i) disable iff (!rst_n_i)
      s_speed_write ##1 !(wr_i && (addr_i == nrtfc_pkg::ADDR_LINK_SPEED))
      |=> rx_rate_o == $past(wdata_i[1:0], 2);
   endproperty
   a_rx_rate: assert property (p_rx_rate) else $error("receive rate not taken from bits 1:0");

   property p_divider_map;
      @(posedge mclk_i) disable iff (!rst_n_i)
      $past(rst_n_i) |-> (tx_divider_o == (nrtfc_pkg::DIV_128 >> tx_rate_o))
                      && (rx_divider_o == (nrtfc_pkg::DIV_128 >> rx_rate_o));
   endproperty
   a_divider_map: assert property (p_divider_map) else $error("divisor does not match rate code");

   property p_link_enable;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (tx_enable_o == rx_enable_o)
      && (tx_enable_o == ((tx_divider_o != nrtfc_pkg::DIV_NONE) && (rx_divider_o != nrtfc_pkg::DIV_NONE)));
   endproperty
   a_link_enable: assert property (p_link_enable) else $error("link enabled with unsupported rate");

   property p_no_parity;
      @(posedge mclk_i) disable iff (!rst_n_i)
      tx_no_parity_o == ($past(frame_reg[7]) && $past(reader_mode_i));
   endproperty
   a_no_parity: assert property (p_no_parity) else $error("parity dropped without reader and bit 7");

   property p_raw_rx;
      @(posedge mclk_i) disable iff (!rst_n_i)
      rx_raw_parity_o |-> (rx_rate_o == nrtfc_pkg::RATE_DIV128) && $past(reader_mode_i);
   endproperty
   a_raw_rx: assert property (p_raw_rx) else $error("raw receive outside reader at slowest rate");

   property p_header;
      @(posedge mclk_i) disable iff (!rst_n_i)
      s_frame_write ##1 (!wr_i && !rate_detect_i)
      |=> (tx_header_o == $past(wdata_i[5], 2)) && (rx_skip_start_o == tx_header_o)
          && (start_byte_o == nrtfc_pkg::START_BYTE);
   endproperty
   a_header: assert property (p_header) else $error("transport header not following bit 5");

   property p_header_detect;
      @(posedge mclk_i) disable iff (!rst_n_i)
      rate_detect_i |=> !tx_header_o;
   endproperty
   a_header_detect: assert property (p_header_detect) else $error("header active in rate detection");

   property p_pulse_slow;
      @(posedge mclk_i) disable iff (!rst_n_i)
      $past(rst_n_i) && ($past(tx_rate_reg) == nrtfc_pkg::RATE_DIV128)
      |-> pulse_valid_o
          && (pulse_width_o == 6'(nrtfc_pkg::PW_BASE_128 + {{2{$past(frame_reg[4])}}, $past(frame_reg[4:1])}));
   endproperty
   a_pulse_slow: assert property (p_pulse_slow) else $error("slow rate pause width wrong");

   property p_pulse_span;
      @(posedge mclk_i) disable iff (!rst_n_i)
      pulse_valid_o && (tx_rate_o == nrtfc_pkg::RATE_DIV16)
      |-> (pulse_width_o >= nrtfc_pkg::PW_MIN_16) && (pulse_width_o <= nrtfc_pkg::PW_MAX_16)
          && (pulse_width_o == 6'(nrtfc_pkg::PW_BASE_16 + {{2{$past(frame_reg[4])}}, $past(frame_reg[4:1])}));
   endproperty
   a_pulse_span: assert property (p_pulse_span) else $error("fast rate pause width out of span");

   property p_anticoll;
      @(posedge mclk_i) disable iff (!rst_n_i)
      s_frame_write ##1 !wr_i |=> anticoll_o == $past(wdata_i[0], 2);
   endproperty
   a_anticoll: assert property (p_anticoll) else $error("anticollision flag not following bit 0");

   property p_reserved_zero;
      @(posedge mclk_i) disable iff (!rst_n_i)
      rd_i && (addr_i == nrtfc_pkg::ADDR_LINK_SPEED) |=> (rdata_o[7:6] == 2'h0) && (rdata_o[3:2] == 2'h0);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved speed bits not zero");
endmodule
`default_nettype wire

/* File: bench/tb_nrtfc_cfg.sv */
`default_nettype none
// =====================================================================
// Self-checking bench for the rate and framing configuration block
// =====================================================================
// One compare: counts, and reports a mismatch at once
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end

module tb_nrtfc_cfg;
   timeunit 1ns;
   timeprecision 1ps;

   // =====================================================================
   // Clock, reset and stimulus signals
   // =====================================================================
   logic mclk_i = 1'b0; // 250 MHz bench clock
   logic rst_n_i = 1'b0; // Held low at start
   logic [7:0] addr = 8'h00; // Register offset
   logic [7:0] wdata = 8'h00; // Write data
   logic wr = 1'b0; // Write strobe
   logic rd = 1'b0; // Read strobe
   logic reader_mode = 1'b0; // Reader versus card emulation
   logic rate_detect = 1'b0; // Target bit rate detection
   logic [7:0] rdata_o; // Read data from the block
   logic [1:0] tx_rate_o, rx_rate_o;
   logic [7:0] tx_divider_o, rx_divider_o, start_byte_o;
   logic tx_enable_o, rx_enable_o, tx_no_parity_o, rx_raw_parity_o;
   logic tx_header_o, rx_skip_start_o, pulse_valid_o, anticoll_o;
   logic [5:0] pulse_width_o;
   int errors = 0; // Mismatch counter
   int num_checks = 0; // Comparison counter
   int seed = 32'hD3E57F1F; // Fixed seed keeps runs repeatable
   logic [7:0] exp_q[$]; // Read expectations, oldest first
   logic rd_q = 1'b0; // Read strobe seen one edge ago
   logic [7:0] exp_rd; // Expectation popped by the monitor

   // Bench clock, half period 2 ns
   always #2 mclk_i = ~mclk_i;

   // =====================================================================
   // Device under test
   // =====================================================================
   nrtfc_cfg u_dut
   (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata_o), .reader_mode_i(reader_mode), .rate_detect_i(rate_detect),
      .tx_rate_o(tx_rate_o), .rx_rate_o(rx_rate_o), .tx_divider_o(tx_divider_o),
      .rx_divider_o(rx_divider_o), .tx_enable_o(tx_enable_o), .rx_enable_o(rx_enable_o),
      .tx_no_parity_o(tx_no_parity_o), .rx_raw_parity_o(rx_raw_parity_o), .tx_header_o(tx_header_o),
      .rx_skip_start_o(rx_skip_start_o), .start_byte_o(start_byte_o), .pulse_width_o(pulse_width_o),
      .pulse_valid_o(pulse_valid_o), .anticoll_o(anticoll_o)
   );

   // =====================================================================
   // Read monitor: data stands only in the cycle after the strobe
   // =====================================================================
   always @(posedge mclk_i)
   begin
      // Read port is undefined until the first reset edge, so skip reset
      if (rst_n_i && rd_q)
      begin
         // Oldest note belongs to this answer
         exp_rd = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
         `CHK("rdata_o", exp_rd, rdata_o)
      end
      else if (rst_n_i)
      begin
         // Outside the answer cycle the port returns zero
         `CHK("rdata_o idle", 8'h00, rdata_o)
      end
      rd_q <= rd & rst_n_i;
   end

   // =====================================================================
   // Bus tasks
   // =====================================================================
   // One access per edge; back to back calls never reassign a strobe twice
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      wr <= w;
      rd <= ~w;
      addr <= a;
      wdata <= d;
      // For a read, d is the expected answer
      if (!w)
         exp_q.push_back(d);
   endtask

   // Drop both strobes
   task automatic idle();
      @(posedge mclk_i);
      wr <= 1'b0;
      rd <= 1'b0;
   endtask

   // Closing task shared with the watchdog
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // =====================================================================
   // Main sequence
   // =====================================================================
   initial
   begin : main
      int base[4], lo[4], hi[4], s, w, t, f;
      logic [1:0] r;
      logic [31:0] rnd;
      logic [7:0] spd, fr, pw;
      logic pv, raw, hdr;
      base = '{35, 18, 9, 5};
      lo = '{27, 12, 5, 2};
      hi = '{42, 24, 13, 8};
      repeat (2) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      #1;
      // Reset state: slowest rate, default width, header byte loaded
      `CHK("tx_divider_o", 8'h80, tx_divider_o)
      `CHK("tx_enable_o", 1'b1, tx_enable_o)
      `CHK("pulse_width_o", 6'h23, pulse_width_o)
      `CHK("start_byte_o", 8'hF0, start_byte_o)
      bus(1'b0, 8'h04, 8'h00);
      bus(1'b0, 8'h05, 8'h00);
      idle();
      $display("test done: reset values");

      // Every tx rate against every trim code, other bits random
      for (t = 0; t < 4; t++)
      begin
         for (f = 0; f < 16; f++)
         begin
            rnd = $random(seed);
            r = rnd[1:0];
            spd = {rnd[3:2], t[1:0], rnd[5:4], r};
            // Header kept clear in rate detection, anticollision only as reader
            fr = {rnd[15:14], rnd[13] & ~rnd[9], f[3:0], rnd[12] & rnd[8]};
            @(posedge mclk_i);
            reader_mode <= rnd[8];
            rate_detect <= rnd[9];
            // Signed trim on the per-rate base, zero when out of range
            s = f[3] ? f - 16 : f;
            w = base[t] + s;
            pv = (w >= lo[t]) && (w <= hi[t]);
            pw = pv ? 8'(w) : 8'h00;
            raw = fr[6] & rnd[8] & (r == 2'h0);
            hdr = fr[5] & ~rnd[9];
            bus(1'b1, 8'h04, spd);
            bus(1'b1, 8'h05, fr);
            bus(1'b1, 8'h10, rnd[23:16]); // Read-only place, ignored
            bus(1'b1, 8'h06, rnd[31:24]); // Unmapped, ignored
            bus(1'b0, 8'h04, spd & 8'h33);
            bus(1'b0, 8'h05, fr);
            bus(1'b0, 8'h33, 8'h00);
            bus(1'b0, 8'h10, {4'h0, hdr, raw, pv, 1'b1});
            idle();
            #1;
            `CHK("tx_rate_o", t[1:0], tx_rate_o)
            `CHK("rx_rate_o", r, rx_rate_o)
            `CHK("tx_divider_o", 8'h80 >> t, tx_divider_o)
            `CHK("rx_divider_o", 8'h80 >> r, rx_divider_o)
            `CHK("rx_enable_o", 1'b1, rx_enable_o)
            `CHK("tx_no_parity_o", fr[7] & rnd[8], tx_no_parity_o)
            `CHK("rx_raw_parity_o", raw, rx_raw_parity_o)
            `CHK("tx_header_o", hdr, tx_header_o)
            `CHK("rx_skip_start_o", hdr, rx_skip_start_o)
            `CHK("pulse_width_o", pw[5:0], pulse_width_o)
            `CHK("pulse_valid_o", pv, pulse_valid_o)
            `CHK("anticoll_o", fr[0], anticoll_o)
         end
      end
      $display("test done: rate and framing sweep");

      // Reset in mid-run clears both registers again
      @(posedge mclk_i);
      rst_n_i <= 1'b0;
      #1;
      `CHK("tx_divider_o in reset", 8'h00, tx_divider_o)
      `CHK("start_byte_o in reset", 8'h00, start_byte_o)
      repeat (2) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      bus(1'b0, 8'h04, 8'h00);
      bus(1'b0, 8'h05, 8'h00);
      idle();
      idle();
      // Off the edge, so the last read answer is checked before the verdict
      #1;
      `CHK("tx_divider_o after reset", 8'h80, tx_divider_o)
      `CHK("pulse_width_o after reset", 6'h23, pulse_width_o)
      $display("test done: second reset");
      give_verdict();
   end

   // =====================================================================
   // Watchdog: the sweep needs about 640 cycles
   // =====================================================================
   initial
   begin
      repeat (20000) @(posedge mclk_i);
      errors++;
      $display("watchdog expired");
      give_verdict();
   end
endmodule
`default_nettype wire
